// file: inc/alsc_pkg.sv
// Package: register map, field layout, timing and types of the light sensor control
//
// Behaviour
// - Config write aborts a running conversion
// - Restart conversion if new settings ask one
// - Range field bits 15:12 chooses full scale
// - Code 1100b selects automatic range
// - Automatic range reported in result exponent
// - Range field resets to automatic code
// - Short time loses resolution on low ranges
// - Result format same for both times
// - Mode 00 off, 01 single, 1x continuous
// - Mode reads single while single-shot runs
// - Single-shot end clears mode to shutdown
// - Shutdown keeps ready and limit flags
// - Config at offset 01h, reset C810h
// - Bits 8:5 ignore writes, others writable
// - Result: exponent 15:12, mantissa 11:0
`default_nettype none
package alsc_pkg;

   //-----------------------------------------------------------------
   // Register map
   //-----------------------------------------------------------------
   localparam logic [7:0]  OFS_RESULT = 8'h00;
   localparam logic [7:0]  OFS_CONFIG = 8'h01;
   localparam logic [15:0] CFG_RESET  = 16'hc810;
   localparam logic [15:0] CFG_WMASK  = 16'hfe1f;
   localparam logic [15:0] RES_RESET  = 16'h0000;

   //-----------------------------------------------------------------
   // Field codes
   //-----------------------------------------------------------------
   localparam logic [3:0]  RANGE_AUTO = 4'hc;
   localparam logic [3:0]  RANGE_MAX  = 4'hb;
   localparam logic [3:0]  RANGE_MIN  = 4'h0;
   localparam logic [3:0]  RANGE_LOSS1 = 4'h5;
   localparam logic [1:0]  MODE_OFF    = 2'h0;
   localparam logic [1:0]  MODE_SINGLE = 2'h1;
   localparam logic [11:0] MANT_LOW    = 12'h400;

   //-----------------------------------------------------------------
   // Timing
   //-----------------------------------------------------------------
   localparam int unsigned CLK_MHZ    = 250;
   localparam int unsigned T_SHORT_MS = 100;
   localparam int unsigned T_LONG_MS  = 800;
   localparam int unsigned CYC_SHORT  = T_SHORT_MS * 1000 * CLK_MHZ;
   localparam int unsigned CYC_LONG   = T_LONG_MS * 1000 * CLK_MHZ;
   localparam int unsigned CNT_W      = 28;

   //-----------------------------------------------------------------
   // Types
   //-----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] range_select;
      logic       conversion_time_sel;
      logic [1:0] mode;
      logic       overflow_flag;
      logic       conversion_ready_flag;
      logic       high_limit_flag;
      logic       low_limit_flag;
      logic [4:0] low_fields;
   } alsc_cfg_t;

   typedef struct packed {
      logic [3:0]  exponent;
      logic [11:0] mantissa;
   } alsc_result_t;

endpackage
`default_nettype wire

// file: rtl/alsc_conv_timer.sv
// Conversion length timer with restart and abort
`timescale 1ns/10ps
`default_nettype none
module alsc_conv_timer #(
   parameter int unsigned SHORT_CYC = alsc_pkg::CYC_SHORT,
   parameter int unsigned LONG_CYC  = alsc_pkg::CYC_LONG
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Control
   input  wire logic start,
   input  wire logic abort,
   input  wire logic long_sel,
   // Status
   output var  logic busy_q,
   output var  logic done_q
);

   logic [alsc_pkg::CNT_W-1:0] cnt_q;
   logic [alsc_pkg::CNT_W-1:0] last_q;
   wire  logic                 at_end;
   wire  logic [alsc_pkg::CNT_W-1:0] last_d;

   //-----------------------------------------------------------------
   // Length select, 0 short, 1 long
   //-----------------------------------------------------------------
   assign last_d = long_sel ? alsc_pkg::CNT_W'(LONG_CYC - 1)
                            : alsc_pkg::CNT_W'(SHORT_CYC - 1);
   assign at_end = busy_q && (cnt_q == last_q);

   // Start wins over abort so a restart is never lost
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         cnt_q  <= '0;
         last_q <= '0;
         done_q <= 1'b0;
      end else begin
         done_q <= at_end && !start && !abort;
         if (start) begin
            busy_q <= 1'b1;
            cnt_q  <= '0;
            last_q <= last_d;
         end else if (abort || at_end) begin
            busy_q <= 1'b0;
         end else if (busy_q) begin
            cnt_q <= cnt_q + alsc_pkg::CNT_W'(1);
         end
      end
   end

   //-----------------------------------------------------------------
   // Checks
   //-----------------------------------------------------------------
   AST_ABORT_STOPS: assert property (@(posedge clk) disable iff (!rst_b)
      abort && !start |=> !busy_q && !done_q)
      else $error("abort left timer running");

   AST_START_FRESH: assert property (@(posedge clk) disable iff (!rst_b)
      start |=> busy_q && cnt_q == '0)
      else $error("start did not restart count");

   AST_DONE_AT_END: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(done_q) |-> $past(cnt_q) == last_q)
      else $error("done not at selected length");

endmodule // alsc_conv_timer
`default_nettype wire

// file: rtl/alsc_config_ctrl.sv
// Configuration register and conversion control of the light sensor
`timescale 1ns/10ps
`default_nettype none
module alsc_config_ctrl #(
   parameter int unsigned SHORT_CYC = alsc_pkg::CYC_SHORT,
   parameter int unsigned LONG_CYC  = alsc_pkg::CYC_LONG
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // Register port from serial front end
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   output var  logic [15:0] REG_RDATA,
   // Converter and limit logic results
   input  wire logic [11:0] ADC_MANTISSA,
   input  wire logic        ADC_OVERFLOW,
   input  wire logic        LIMIT_HIGH,
   input  wire logic        LIMIT_LOW,
   // Converter control
   output var  logic        CONV_RUN,
   output var  logic [3:0]  CONV_RANGE,
   output var  logic        CONV_LONG,
   output var  logic [1:0]  CONV_RES_LOSS,
   output var  logic        CONV_DONE
);

   //-----------------------------------------------------------------
   // Decode functions
   //-----------------------------------------------------------------
   // Reserved codes are clamped so the converter never sees them
   function automatic logic [3:0] eff_range(input logic [3:0] rn,
                                            input logic [3:0] autor);
      if (rn == alsc_pkg::RANGE_AUTO)
         eff_range = autor;
      else if (rn > alsc_pkg::RANGE_AUTO)
         eff_range = alsc_pkg::RANGE_MAX;
      else
         eff_range = rn;
   endfunction

   // Bits of resolution lost with the short time
   function automatic logic [1:0] res_loss(input logic [3:0] rng,
                                           input logic       long_t);
      if (long_t || rng > alsc_pkg::RANGE_LOSS1)
         res_loss = 2'h0;
      else if (rng == alsc_pkg::RANGE_LOSS1)
         res_loss = 2'h1;
      else if (rng == alsc_pkg::RANGE_MIN)
         res_loss = 2'h3;
      else
         res_loss = 2'h2;
   endfunction

   //-----------------------------------------------------------------
   // State
   //-----------------------------------------------------------------
   alsc_pkg::alsc_cfg_t    cfg_q;
   alsc_pkg::alsc_cfg_t    cfg_d;
   alsc_pkg::alsc_cfg_t    wr_cfg;
   alsc_pkg::alsc_result_t res_q;
   logic [3:0]             used_q;
   logic [3:0]             auto_q;
   logic [3:0]             auto_d;
   logic [15:0]            rdata_q;
   logic [3:0]             crange_q;
   logic                   clong_q;
   logic [1:0]             closs_q;
   logic                   cdone_q;
   wire  logic             busy;
   wire  logic             tdone;

   //-----------------------------------------------------------------
   // Access decode
   //-----------------------------------------------------------------
   wire logic cfg_wr   = REG_WR && (REG_ADDR == alsc_pkg::OFS_CONFIG);
   wire logic cfg_rd   = REG_RD && (REG_ADDR == alsc_pkg::OFS_CONFIG);
   wire logic res_rd   = REG_RD && (REG_ADDR == alsc_pkg::OFS_RESULT);
   wire logic wr_off   = wr_cfg.mode == alsc_pkg::MODE_OFF;
   wire logic is_auto  = cfg_q.range_select == alsc_pkg::RANGE_AUTO;
   wire logic is_cont  = cfg_q.mode[1];
   wire logic is_ss    = cfg_q.mode == alsc_pkg::MODE_SINGLE;

   // Only writable bits come from the host, flag bits keep theirs
   assign wr_cfg = alsc_pkg::alsc_cfg_t'((REG_WDATA & alsc_pkg::CFG_WMASK)
                  | (cfg_q & ~alsc_pkg::CFG_WMASK));

   //-----------------------------------------------------------------
   // Automatic range stepping
   //-----------------------------------------------------------------
   // Overflow below top range: raise range and convert again
   wire logic bump    = tdone && is_auto && ADC_OVERFLOW
                        && (used_q != alsc_pkg::RANGE_MAX);
   wire logic fin     = tdone && !bump;
   wire logic step_dn = fin && is_auto && (used_q != alsc_pkg::RANGE_MIN)
                        && (ADC_MANTISSA < alsc_pkg::MANT_LOW);

   // Down step only one range per conversion keeps it stable
   always_comb begin
      auto_d = auto_q;
      if (bump)
         auto_d = 4'(used_q + 4'h1);
      else if (step_dn)
         auto_d = 4'(used_q - 4'h1);
      else if (fin && is_auto)
         auto_d = used_q;
   end

   //-----------------------------------------------------------------
   // Conversion start and abort
   //-----------------------------------------------------------------
   wire logic t_start = cfg_wr ? !wr_off
                               : (bump || (fin && is_cont));
   wire logic t_abort = cfg_wr && wr_off;
   wire logic s_long  = cfg_wr ? wr_cfg.conversion_time_sel
                               : cfg_q.conversion_time_sel;
   wire logic [3:0] s_rng = eff_range(cfg_wr ? wr_cfg.range_select
                                             : cfg_q.range_select, auto_d);

   //-----------------------------------------------------------------
   // Configuration next value
   //-----------------------------------------------------------------
   always_comb begin
      cfg_d = cfg_q;
      if (cfg_wr) begin
         cfg_d = wr_cfg;
      end else if (fin && is_ss) begin
         cfg_d.mode = alsc_pkg::MODE_OFF;
      end
      // Ready clears on read or on a non-shutdown write
      if (cfg_rd || (cfg_wr && !wr_off))
         cfg_d.conversion_ready_flag = 1'b0;
      // Completion sets, and wins over any clear
      if (fin) begin
         cfg_d.conversion_ready_flag = 1'b1;
         cfg_d.overflow_flag         = ADC_OVERFLOW;
         cfg_d.high_limit_flag       = LIMIT_HIGH;
         cfg_d.low_limit_flag        = LIMIT_LOW;
      end
   end

   //-----------------------------------------------------------------
   // Read data select
   //-----------------------------------------------------------------
   wire logic [15:0] rd_sel = res_rd ? 16'(res_q)
                            : cfg_rd ? 16'(cfg_q) : 16'h0000;

   //-----------------------------------------------------------------
   // Registers
   //-----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cfg_q <= alsc_pkg::alsc_cfg_t'(alsc_pkg::CFG_RESET);
         auto_q <= alsc_pkg::RANGE_MAX;
      end else begin
         cfg_q  <= cfg_d;
         auto_q <= auto_d;
      end
   end

   // Result keeps the same layout for either time
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         res_q <= alsc_pkg::alsc_result_t'(alsc_pkg::RES_RESET);
      end else if (fin) begin
         res_q.exponent <= used_q;
         res_q.mantissa <= ADC_MANTISSA;
      end
   end

   // Settings applied to the conversion now running
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         used_q   <= alsc_pkg::RANGE_MAX;
         crange_q <= alsc_pkg::RANGE_MAX;
         clong_q  <= 1'b1;
         closs_q  <= 2'h0;
      end else if (t_start) begin
         used_q   <= s_rng;
         crange_q <= s_rng;
         clong_q  <= s_long;
         closs_q  <= res_loss(s_rng, s_long);
      end
   end

   // Read data is registered, valid the cycle after the strobe
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata_q <= 16'h0000;
         cdone_q <= 1'b0;
      end else begin
         cdone_q <= fin;
         if (REG_RD)
            rdata_q <= rd_sel;
      end
   end

   //-----------------------------------------------------------------
   // Timer
   //-----------------------------------------------------------------
   alsc_conv_timer #(
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC)
   ) u_timer (
      .clk      (CLK),
      .rst_b    (RST_B),
      .start    (t_start),
      .abort    (t_abort),
      .long_sel (s_long),
      .busy_q   (busy),
      .done_q   (tdone)
   );

   //-----------------------------------------------------------------
   // Outputs
   //-----------------------------------------------------------------
   assign REG_RDATA     = rdata_q;
   assign CONV_RUN      = busy;
   assign CONV_RANGE    = crange_q;
   assign CONV_LONG     = clong_q;
   assign CONV_RES_LOSS = closs_q;
   assign CONV_DONE     = cdone_q;

   //-----------------------------------------------------------------
   // Checks
   //-----------------------------------------------------------------
   AST_WR_ABORT: assert property (@(posedge CLK) disable iff (!RST_B)
      cfg_wr && busy && wr_off |=> !CONV_RUN)
      else $error("shutdown write did not abort");

   AST_WR_RESTART: assert property (@(posedge CLK) disable iff (!RST_B)
      cfg_wr && !wr_off |=> CONV_RUN && CONV_RANGE == $past(s_rng))
      else $error("write did not restart conversion");

   AST_AUTO_UP: assert property (@(posedge CLK) disable iff (!RST_B)
      bump && !cfg_wr |=> CONV_RUN && CONV_RANGE == 4'($past(used_q) + 4'h1))
      else $error("auto range did not step up");

   AST_EXP_REPORT: assert property (@(posedge CLK) disable iff (!RST_B)
      fin |=> res_q.exponent == $past(used_q)
              && res_q.mantissa == $past(ADC_MANTISSA))
      else $error("result not captured");

   AST_SS_HOLD: assert property (@(posedge CLK) disable iff (!RST_B)
      is_ss && busy && !fin && !cfg_wr |=> cfg_q.mode == alsc_pkg::MODE_SINGLE)
      else $error("single mode lost while converting");

   AST_SS_END: assert property (@(posedge CLK) disable iff (!RST_B)
      fin && is_ss && !cfg_wr |=> cfg_q.mode == alsc_pkg::MODE_OFF && !CONV_RUN)
      else $error("single shot did not shut down");

   AST_OFF_KEEP: assert property (@(posedge CLK) disable iff (!RST_B)
      cfg_wr && wr_off && !fin && !cfg_rd |=>
         $stable(cfg_q.conversion_ready_flag) && $stable(cfg_q.high_limit_flag)
         && $stable(cfg_q.low_limit_flag))
      else $error("shutdown changed flags");

   AST_RO_BITS: assert property (@(posedge CLK) disable iff (!RST_B)
      cfg_wr && !fin |=> $stable(cfg_q.overflow_flag)
         && cfg_q.range_select == $past(REG_WDATA[15:12]))
      else $error("write mask broken");

   AST_CONT: assert property (@(posedge CLK) disable iff (!RST_B)
      fin && is_cont && !cfg_wr |=> CONV_RUN
         && CONV_LONG == $past(cfg_q.conversion_time_sel))
      else $error("continuous mode did not restart");

   AST_CRF_SET: assert property (@(posedge CLK) disable iff (!RST_B)
      fin |=> cfg_q.conversion_ready_flag)
      else $error("completion did not set ready flag");

   AST_CRF_CLEAR: assert property (@(posedge CLK) disable iff (!RST_B)
      cfg_rd && !fin |=> !cfg_q.conversion_ready_flag)
      else $error("read did not clear ready flag");

   AST_OFF_IDLE: assert property (@(posedge CLK) disable iff (!RST_B)
      cfg_q.mode == alsc_pkg::MODE_OFF && !cfg_wr |=> !CONV_RUN)
      else $error("converter running in shutdown");

   AST_LONG_FULL: assert property (@(posedge CLK) disable iff (!RST_B)
      CONV_LONG |-> CONV_RES_LOSS == 2'h0)
      else $error("long conversion reports lost bits");

   AST_SHORT_MIN: assert property (@(posedge CLK) disable iff (!RST_B)
      !CONV_LONG && CONV_RANGE == alsc_pkg::RANGE_MIN |-> CONV_RES_LOSS == 2'h3)
      else $error("lowest range short loss wrong");

   AST_RANGE_LEGAL: assert property (@(posedge CLK) disable iff (!RST_B)
      CONV_RANGE <= alsc_pkg::RANGE_MAX)
      else $error("converter given a reserved range");

   AST_AUTO_DOWN: assert property (@(posedge CLK) disable iff (!RST_B)
      step_dn |=> auto_q == 4'($past(used_q) - 4'h1))
      else $error("auto range did not step down");

   AST_RD_CFG: assert property (@(posedge CLK) disable iff (!RST_B)
      cfg_rd |=> REG_RDATA == $past(16'(cfg_q)))
      else $error("config read returned wrong word");

   AST_RD_RES: assert property (@(posedge CLK) disable iff (!RST_B)
      res_rd |=> REG_RDATA == $past(16'(res_q)))
      else $error("result read returned wrong word");

endmodule // alsc_config_ctrl
`default_nettype wire

// file: testbench/alsc_host_model.sv
// Host side model driving the parallel register port of the light sensor control
`timescale 1ns/10ps
`default_nettype none
module alsc_host_model (
   // Clock
   input  wire logic        clk,
   // Register port
   output var  logic        reg_wr,
   output var  logic        reg_rd,
   output var  logic [7:0]  reg_addr,
   output var  logic [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata
);
   //-----------------------------------------------------------------
   // Idle state of the port
   //-----------------------------------------------------------------
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 16'h0000;
   end

   // One-cycle write strobe; reserved range codes are never sent
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= (d[15:12] > alsc_pkg::RANGE_AUTO)
                   ? {alsc_pkg::RANGE_AUTO, d[11:0]} : d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a; // Stale bus value must not look valid
      reg_wdata <= ~d;
      #1;
   endtask

   // One-cycle read strobe, data taken once the strobe edge has landed
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule // alsc_host_model
`default_nettype wire

// file: testbench/light_sensor_config_control_tb.sv
// Self-checking testbench of the light sensor configuration control
`timescale 1ns/10ps
`default_nettype none
module light_sensor_config_control_tb;
   //-----------------------------------------------------------------
   // Signals and reference model state
   //-----------------------------------------------------------------
   localparam int SC = 20; // Shortened conversion counts keep the run brief
   localparam int LC = 80;
   logic        CLK = 1'b0;
   logic        RST_B = 1'b0;
   logic        REG_WR, REG_RD;
   logic [7:0]  REG_ADDR;
   logic [15:0] REG_WDATA, REG_RDATA;
   logic [11:0] ADC_MANTISSA = 12'h000;
   logic        ADC_OVERFLOW = 1'b0;
   logic        LIMIT_HIGH = 1'b0;
   logic        LIMIT_LOW = 1'b0;
   logic        CONV_RUN, CONV_LONG, CONV_DONE;
   logic [3:0]  CONV_RANGE;
   logic [1:0]  CONV_RES_LOSS;
   logic [15:0] lfsr = 16'h000e;
   logic [15:0] exp_cfg, exp_res, got;
   int          miscompares = 0;
   int          compares = 0;
   int          dones;

   always #2 CLK = ~CLK;

   alsc_config_ctrl #(.SHORT_CYC(SC), .LONG_CYC(LC)) alsc_config_ctrl_i (
      .CLK(CLK), .RST_B(RST_B), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .ADC_MANTISSA(ADC_MANTISSA),
      .ADC_OVERFLOW(ADC_OVERFLOW), .LIMIT_HIGH(LIMIT_HIGH), .LIMIT_LOW(LIMIT_LOW),
      .CONV_RUN(CONV_RUN), .CONV_RANGE(CONV_RANGE), .CONV_LONG(CONV_LONG),
      .CONV_RES_LOSS(CONV_RES_LOSS), .CONV_DONE(CONV_DONE));

   alsc_host_model alsc_host_model_i (
      .clk(CLK), .reg_wr(REG_WR), .reg_rd(REG_RD), .reg_addr(REG_ADDR),
      .reg_wdata(REG_WDATA), .reg_rdata(REG_RDATA));

   //-----------------------------------------------------------------
   // Helpers
   //-----------------------------------------------------------------
   // Reports and counts a difference at once
   task automatic check(input logic [15:0] g, input logic [15:0] e, input string what);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
      end
   endtask

   // Verdict and end of run, shared by the sequence and the watchdog
   task automatic results();
      if (miscompares == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Bits of resolution lost for a range and time choice
   function automatic logic [1:0] loss(input logic [3:0] r, input logic ct);
      if (ct || r > alsc_pkg::RANGE_LOSS1) return 2'h0;
      if (r == alsc_pkg::RANGE_LOSS1) return 2'h1;
      return (r == alsc_pkg::RANGE_MIN) ? 2'h3 : 2'h2;
   endfunction

   // Converter levels held steady over the following conversion
   task automatic set_adc(input logic [11:0] om, input logic [11:0] am, input logic ovf);
      @(posedge CLK);
      lfsr = lfsr_next(lfsr);
      ADC_MANTISSA <= (lfsr[11:0] | om) & am;
      ADC_OVERFLOW <= ovf;
      LIMIT_HIGH   <= lfsr[12];
      LIMIT_LOW    <= lfsr[13];
      #1;
   endtask

   // Config write plus model update; flag bits are not writable
   task automatic wr_cfg(input logic [15:0] d);
      alsc_host_model_i.wr(alsc_pkg::OFS_CONFIG, d);
      exp_cfg = (d & alsc_pkg::CFG_WMASK) | (exp_cfg & ~alsc_pkg::CFG_WMASK);
      if (d[10:9] != alsc_pkg::MODE_OFF) exp_cfg[7] = 1'b0;
   endtask

   task automatic rd_cfg();
      alsc_host_model_i.rd(alsc_pkg::OFS_CONFIG, got);
      check(got, exp_cfg, "config");
      exp_cfg[7] = 1'b0; // Read clears the ready flag
   endtask

   task automatic rd_res();
      alsc_host_model_i.rd(alsc_pkg::OFS_RESULT, got);
      check(got, exp_res, "result");
   endtask

   // Counts busy cycles up to the completion pulse, then updates the model
   task automatic conv(input int n, input logic cont, input logic [3:0] er);
      int runs;
      runs = 0;
      for (int i = 0; i < 3 * LC; i++) begin
         if (CONV_RUN === 1'b1) runs++;
         @(posedge CLK);
         #1;
         if (CONV_DONE === 1'b1) break;
      end
      check(16'(runs), 16'(n), "busy length");
      check({15'h0, CONV_RUN}, {15'h0, cont}, "run after done");
      exp_res = {er, ADC_MANTISSA};
      exp_cfg[8:5] = {ADC_OVERFLOW, 1'b1, LIMIT_HIGH, LIMIT_LOW};
      if (!cont) exp_cfg[10:9] = alsc_pkg::MODE_OFF;
   endtask

   //-----------------------------------------------------------------
   // Main sequence
   //-----------------------------------------------------------------
   initial begin
      exp_cfg = alsc_pkg::CFG_RESET;
      exp_res = alsc_pkg::RES_RESET;
      repeat (5) @(posedge CLK);
      RST_B <= 1'b1;
      #1;
      check({14'h0, CONV_LONG, CONV_RUN}, 16'h0002, "reset outputs");
      rd_cfg();
      rd_res();
      alsc_host_model_i.rd(8'h05, got);
      check(got, 16'h0000, "unmapped read");
      alsc_host_model_i.wr(alsc_pkg::OFS_RESULT, 16'hffff);
      rd_res();
      // Every fixed range with both times, each write aborting the last
      for (int r = 0; r < 12; r++) begin
         for (int ct = 0; ct < 2; ct++) begin
            wr_cfg({4'(r), 1'(ct), 2'h1, 9'h00a});
            check({14'h0, CONV_RES_LOSS}, {14'h0, loss(4'(r), 1'(ct))}, "loss");
            check({11'h0, CONV_RANGE, CONV_RUN}, {11'h0, 4'(r), 1'b1}, "range");
            check({15'h0, CONV_LONG}, {15'h0, 1'(ct)}, "time");
         end
      end
      set_adc(12'h800, 12'hfff, 1'b0);
      wr_cfg(16'hba0a);
      conv(LC, 1'b0, 4'hb);
      rd_res();
      wr_cfg(16'h520a);
      conv(SC, 1'b0, 4'h5);
      rd_res();
      wr_cfg(16'h79ff);
      rd_cfg();
      // Abort by a shutdown write: no completion, flags kept
      wr_cfg(16'h220a);
      rd_cfg();
      wr_cfg(16'h200a);
      check({15'h0, CONV_RUN}, 16'h0000, "abort");
      dones = 0;
      repeat (SC + 4) begin
         @(posedge CLK);
         #1;
         if (CONV_DONE !== 1'b0) dones++;
      end
      check(16'(dones), 16'h0000, "done after abort");
      rd_res();
      rd_cfg();
      // Continuous with both codes
      set_adc(12'h000, 12'hfff, 1'b0);
      wr_cfg(16'h340a);
      conv(SC, 1'b1, 4'h3);
      conv(SC, 1'b1, 4'h3);
      rd_cfg();
      rd_res();
      wr_cfg(16'h360a);
      conv(SC, 1'b1, 4'h3);
      wr_cfg(16'h300a);
      rd_cfg();
      // Automatic range: stay, step down, overflow bump
      set_adc(12'h400, 12'hfff, 1'b0);
      wr_cfg(16'hc20a);
      check({12'h0, CONV_RANGE}, 16'h000b, "auto start");
      conv(SC, 1'b0, 4'hb);
      rd_res();
      set_adc(12'h000, 12'h3ff, 1'b0);
      wr_cfg(16'hc20a);
      conv(SC, 1'b0, 4'hb);
      rd_res();
      set_adc(12'h000, 12'hfff, 1'b1);
      wr_cfg(16'hc20a);
      check({12'h0, CONV_RANGE}, 16'h000a, "auto down");
      conv(2 * SC, 1'b0, 4'hb);
      rd_res();
      rd_cfg();
      results();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #200000;
      miscompares++;
      results();
   end
endmodule // light_sensor_config_control_tb
`default_nettype wire
